// *** inc/dsrwd_pkg.sv ***
package dsrwd_pkg;

    typedef enum logic [1:0] {
        DSRWD_TO_50MS = 2'h0,
        DSRWD_TO_100MS = 2'h1,
        DSRWD_TO_200MS = 2'h2,
        DSRWD_TO_400MS = 2'h3
    } dsrwd_opt_t;

    // Gray-coded along undervolt -> hold -> run
    typedef enum logic [1:0] {
        DSRWD_ST_UNDERVOLT = 2'b00,
        DSRWD_ST_HOLD = 2'b01,
        DSRWD_ST_RUN = 2'b11
    } dsrwd_state_t;

endpackage

// *** inc/dsrwd_regs.svh ***
`ifndef DSRWD_REGS_SVH
`define DSRWD_REGS_SVH

// Core clock period, in picoseconds
`define DSRWD_CLK_PERIOD_PS 64'd20000

// Reset timeout options in milliseconds
`define DSRWD_RST_TO1_MS 64'd50
`define DSRWD_RST_TO2_MS 64'd100
`define DSRWD_RST_TO3_MS 64'd200
`define DSRWD_RST_TO4_MS 64'd400

// Watchdog timeout window in milliseconds
`define DSRWD_WD_MIN_MS 64'd1200
`define DSRWD_WD_NOM_MS 64'd1600
`define DSRWD_WD_MAX_MS 64'd2000

// Milliseconds to clock cycles
`define DSRWD_MS_TO_CYC(ms) (((ms) * 64'd1000000000) / `DSRWD_CLK_PERIOD_PS)

// Timeout option encodings
`define DSRWD_OPT_50MS 2'h0
`define DSRWD_OPT_100MS 2'h1
`define DSRWD_OPT_200MS 2'h2
`define DSRWD_OPT_400MS 2'h3

`endif

// *** tb/dsrwd_cpu_model.sv ***
`timescale 1ns/10ps
module dsrwd_cpu_model #(parameter int PERIOD = 50) (
    input wire logic clk_in, // Clock
    input wire logic run_in, // Kick periodically
    input wire logic nudge_in, // One extra toggle
    output logic kick_out // Kick pin
);
    int tick;
    initial begin
        kick_out = 1'b0;
        tick = 0;
    end
    always @(posedge clk_in) begin
        tick <= (run_in && tick < PERIOD - 1) ? tick + 1 : 0;
        if ((run_in && tick == PERIOD - 1) || nudge_in) begin
            kick_out <= ~kick_out;
        end
    end
endmodule

// *** tb/dsrwd_top_chk.sv ***
`timescale 1ns/10ps
module dsrwd_chk #(parameter int RST_CYC = 80, parameter int WD_CYC = 200) (
    input wire logic CORE_CLK_IN, // Clock
    input wire logic RST_B_IN, // Reset
    input wire logic PRIMARY_SUPPLY_SENSE_IN, // Low supply
    input wire logic SECONDARY_SUPPLY_SENSE_IN, // Low supply
    input wire logic WATCHDOG_KICK_IN, // Kick
    input wire logic SUPERVISOR_RESET_N_OUT, // Level
    input wire logic SUPERVISOR_RESET_N_OE_N_OUT, // Enable
    input wire logic WATCHDOG_EXPIRED_N_OUT, // Level
    input wire logic WATCHDOG_EXPIRED_N_OE_N_OUT // Enable
);
    wire logic rst_pin = SUPERVISOR_RESET_N_OE_N_OUT | SUPERVISOR_RESET_N_OUT;
    wire logic wd_pin = WATCHDOG_EXPIRED_N_OE_N_OUT | WATCHDOG_EXPIRED_N_OUT;
    wire logic uv = PRIMARY_SUPPLY_SENSE_IN | SECONDARY_SUPPLY_SENSE_IN;
    int good_cnt;
    int idle_cnt;
    logic kick_r;
    // Cycles since both supplies good, and since the last kick or reset
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            good_cnt <= 0;
            idle_cnt <= 0;
            kick_r <= 1'b0;
        end else begin
            good_cnt <= uv ? 0 : good_cnt + 1;
            idle_cnt <= (!rst_pin || kick_r != WATCHDOG_KICK_IN) ? 0 : idle_cnt + 1;
            kick_r <= WATCHDOG_KICK_IN;
        end
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    uv_reset_a:
    assert property (uv [*2] |-> ##[0:3] !rst_pin) else $error("reset not low");
    uv_watchdog_a:
    assert property (uv [*2] |-> ##[0:3] !wd_pin) else $error("watchdog not low");
    hold_low_a:
    assert property (good_cnt > 3 && good_cnt < RST_CYC |-> !rst_pin) else $error("early release");
    hold_release_a:
    assert property ($rose(rst_pin) |-> good_cnt >= RST_CYC && good_cnt <= RST_CYC + 4)
        else $error("hold length wrong");
    reset_cause_a:
    assert property ($fell(rst_pin) |-> good_cnt < 4) else $error("reset without undervolt");
    wd_expire_a:
    assert property ($fell(wd_pin) |-> good_cnt < 4 ||
        (idle_cnt >= WD_CYC - 2 && idle_cnt <= WD_CYC + 4)) else $error("expiry time wrong");
    wd_overdue_a:
    assert property (idle_cnt == WD_CYC + 5 |-> !wd_pin) else $error("no expiry");
    wd_latch_a:
    assert property ($rose(wd_pin) |-> idle_cnt < 6 || good_cnt < 6) else $error("bad release");
    wd_kick_a:
    assert property ($changed(WATCHDOG_KICK_IN) && !uv && rst_pin |-> ##[3:5] wd_pin)
        else $error("kick ignored");
    uv_recover_a:
    assert property (good_cnt == 6 && !rst_pin |-> wd_pin) else $error("watchdog held in hold");
    cover property ($rose(rst_pin));
    cover property ($fell(wd_pin) && rst_pin);
    cover property ($rose(wd_pin) && rst_pin);
endmodule

// *** tb/dsrwd_top_test.sv ***
`timescale 1ns/10ps
module dsrwd_top_test;
    localparam int RC = 80;
    localparam int WC = 200;
    logic clk = 1'b0, rst_b = 1'b0, prim = 1'b0, sec = 1'b0, run = 1'b0, nudge = 1'b0;
    wire logic kick, r_lvl, r_oe_n, w_lvl, w_oe_n;
    wire logic rst_pin = r_oe_n | r_lvl;
    wire logic wd_pin = w_oe_n | w_lvl;
    int err_count = 0, check_count = 0, cyc = 0, n;
    dsrwd_top #(.RST_TO1_CYC(27'h14), .RST_TO2_CYC(27'h28), .RST_TO3_CYC(27'h50),
        .RST_TO4_CYC(27'ha0), .WD_TIMEOUT_CYC(27'hc8)) dsrwd_top_i (.CORE_CLK_IN(clk),
        .RST_B_IN(rst_b), .PRIMARY_SUPPLY_SENSE_IN(prim), .SECONDARY_SUPPLY_SENSE_IN(sec),
        .WATCHDOG_KICK_IN(kick), .SUPERVISOR_RESET_N_OUT(r_lvl),
        .SUPERVISOR_RESET_N_OE_N_OUT(r_oe_n), .WATCHDOG_EXPIRED_N_OUT(w_lvl),
        .WATCHDOG_EXPIRED_N_OE_N_OUT(w_oe_n));
    dsrwd_cpu_model dsrwd_cpu_model_i (.clk_in(clk), .run_in(run),
        .nudge_in(nudge), .kick_out(kick));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded wait for a pin to reach a level; k returns the cycles taken
    task wait_pin(input bit wd, input logic lvl, output int k);
        k = 0;
        while ((wd ? wd_pin : rst_pin) !== lvl && k < 1000) begin
            cycles(1);
            k++;
        end
    endtask
    task t_power_up;
        cycles(20);
        check({rst_pin, wd_pin}, 2'b00);
        @(posedge clk) rst_b <= 1'b1;
        wait_pin(0, 1'b1, n);
        check(n >= RC && n <= RC + 4, 1);
        check(wd_pin, 1);
    endtask
    // Idle kick at both levels; expiry, then a single toggle releases it
    task t_expire;
        for (int i = 0; i < 2; i++) begin
            wait_pin(1, 1'b0, n);
            check(n >= WC - 2 && n <= WC + 4, 1);
            cycles(50);
            check({rst_pin, wd_pin}, 2'b10);
            @(posedge clk) nudge <= 1'b1;
            @(posedge clk) nudge <= 1'b0;
            cycles(5);
            check(wd_pin, 1);
        end
    endtask
    task t_kicked;
        @(posedge clk) run <= 1'b1;
        cycles(600);
        check(wd_pin, 1);
        @(posedge clk) run <= 1'b0;
    endtask
    // Second supply still low when the first recovers: hold timed from the last
    task t_undervolt(input bit both);
        @(posedge clk) prim <= 1'b1;
        sec <= both;
        cycles(4);
        check({rst_pin, wd_pin}, 2'b00);
        @(posedge clk) prim <= 1'b0;
        if (both) begin
            cycles(30);
            check(rst_pin, 0);
            @(posedge clk) sec <= 1'b0;
        end
        cycles(6);
        check({rst_pin, wd_pin}, 2'b01);
        wait_pin(0, 1'b1, n);
        check(n >= RC - 8 && n <= RC, 1);
    endtask
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        t_power_up();
        t_expire();
        t_kicked();
        t_undervolt(1'b0);
        t_undervolt(1'b1);
        conclude();
    end
endmodule
bind dsrwd_top dsrwd_chk #(.RST_CYC(RST_TO3_CYC), .WD_CYC(WD_TIMEOUT_CYC)) dsrwd_chk_i (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
    .PRIMARY_SUPPLY_SENSE_IN(PRIMARY_SUPPLY_SENSE_IN),
    .SECONDARY_SUPPLY_SENSE_IN(SECONDARY_SUPPLY_SENSE_IN), .WATCHDOG_KICK_IN(WATCHDOG_KICK_IN),
    .SUPERVISOR_RESET_N_OUT(SUPERVISOR_RESET_N_OUT),
    .SUPERVISOR_RESET_N_OE_N_OUT(SUPERVISOR_RESET_N_OE_N_OUT),
    .WATCHDOG_EXPIRED_N_OUT(WATCHDOG_EXPIRED_N_OUT),
    .WATCHDOG_EXPIRED_N_OE_N_OUT(WATCHDOG_EXPIRED_N_OE_N_OUT));

// *** verilog/dsrwd_top.sv ***
`timescale 1ns/10ps
`include "dsrwd_regs.svh"
// Overview of operation
// RL1 - Reset output is asserted while either supply-monitor flag reports under-voltage.
// RL2 - After the last flag clears, reset stays asserted for one full reset timeout, then releases.
// RL3 - The reset timeout is one of four build options: 50, 100, 200 or 400 ms.
// RL4 - With no other option chosen the reset timeout is 200 ms.
// RL5 - The watchdog timeout is nominally 1.6 s and always between 1.2 s and 2 s.
// RL6 - A kick input held at one level beyond the watchdog timeout overflows the counter.
// RL7 - A timed-out watchdog output stays low until a kick transition is seen.
// RL8 - The watchdog counter clears while reset is asserted and on every kick transition.
// RL9 - A watchdog timeout never affects the reset output.
// RL10 - The watchdog output is also asserted while reset is held by an under-voltage.
// RL11 - The watchdog output deasserts at once when its cause ends, with no timeout.
// RL12 - The watchdog cannot be disabled; a never-toggling kick input still times out.
// RL13 - Both outputs are active low.
// RL14 - Each output is built as open-drain or push-pull by a fixed build choice.
// RL15 - Kick input and supply flags are synchronised and kicks are found by sample compare.
// RL16 - The supervised processor kicks well inside the minimum watchdog timeout.
module dsrwd_top #(
    parameter dsrwd_pkg::dsrwd_opt_t TIMEOUT_OPTION = dsrwd_pkg::DSRWD_TO_200MS, // [RL4]
    parameter bit RESET_OPEN_DRAIN = 1'b1,
    parameter bit WATCHDOG_OPEN_DRAIN = 1'b1,
    parameter logic [26:0] RST_TO1_CYC = 27'(`DSRWD_MS_TO_CYC(`DSRWD_RST_TO1_MS)),
    parameter logic [26:0] RST_TO2_CYC = 27'(`DSRWD_MS_TO_CYC(`DSRWD_RST_TO2_MS)),
    parameter logic [26:0] RST_TO3_CYC = 27'(`DSRWD_MS_TO_CYC(`DSRWD_RST_TO3_MS)),
    parameter logic [26:0] RST_TO4_CYC = 27'(`DSRWD_MS_TO_CYC(`DSRWD_RST_TO4_MS)),
    parameter logic [26:0] WD_TIMEOUT_CYC = 27'(`DSRWD_MS_TO_CYC(`DSRWD_WD_NOM_MS))
) (
    input wire logic CORE_CLK_IN, // 50 MHz core clock
    input wire logic RST_B_IN, // Asynchronous reset, active low
    input wire logic PRIMARY_SUPPLY_SENSE_IN, // High while primary supply is below trip
    input wire logic SECONDARY_SUPPLY_SENSE_IN, // High while secondary supply is below trip
    input wire logic WATCHDOG_KICK_IN, // Kick pin from supervised processor
    output logic SUPERVISOR_RESET_N_OUT, // Reset pin output level, active low
    output logic SUPERVISOR_RESET_N_OE_N_OUT, // Reset pin driver enable, active low
    output logic WATCHDOG_EXPIRED_N_OUT, // Watchdog pin output level, active low
    output logic WATCHDOG_EXPIRED_N_OE_N_OUT // Watchdog pin driver enable, active low
);

    // Synchronisers: first stage feeds only the second stage
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic kick_prev_r;

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {WATCHDOG_KICK_IN, SECONDARY_SUPPLY_SENSE_IN,
                        PRIMARY_SUPPLY_SENSE_IN}; // [RL15]
            sync2_r <= sync1_r; // [RL15]
        end
    end

    wire logic undervolt = sync2_r[0] | sync2_r[1]; // [RL1]
    wire logic kick_s = sync2_r[2];

    // Previous kick sample; reset seeds it to 0, so a pin held high after reset counts as one kick
    logic kick_seen_r;
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            kick_prev_r <= 1'b0;
            kick_seen_r <= 1'b0;
        end else begin
            kick_prev_r <= kick_s;
            kick_seen_r <= 1'b1;
        end
    end

    wire logic kick_edge = kick_seen_r & (kick_s ^ kick_prev_r); // [RL15]

    // Reset timeout selection, fixed at build
    wire logic [26:0] rst_to_cyc =
        (TIMEOUT_OPTION == dsrwd_pkg::DSRWD_TO_50MS) ? RST_TO1_CYC :
        (TIMEOUT_OPTION == dsrwd_pkg::DSRWD_TO_100MS) ? RST_TO2_CYC :
        (TIMEOUT_OPTION == dsrwd_pkg::DSRWD_TO_400MS) ? RST_TO4_CYC :
        RST_TO3_CYC; // [RL3] [RL4]

    // Supervisor state machine
    dsrwd_pkg::dsrwd_state_t state_r;
    dsrwd_pkg::dsrwd_state_t state_nxt;
    logic [26:0] rst_cnt_r;
    logic [26:0] rst_cnt_nxt;

    wire logic hold_done = (rst_cnt_r >= rst_to_cyc - 27'h1);

    always_comb begin
        state_nxt = state_r;
        rst_cnt_nxt = rst_cnt_r;
        unique case (state_r)
            dsrwd_pkg::DSRWD_ST_UNDERVOLT: begin
                rst_cnt_nxt = 27'h0;
                if (!undervolt) begin
                    state_nxt = dsrwd_pkg::DSRWD_ST_HOLD;
                end
            end
            dsrwd_pkg::DSRWD_ST_HOLD: begin
                // Any dip restarts the timeout from the final recovery
                if (undervolt) begin
                    state_nxt = dsrwd_pkg::DSRWD_ST_UNDERVOLT; // [RL1] [RL2]
                    rst_cnt_nxt = 27'h0;
                end else if (hold_done) begin
                    state_nxt = dsrwd_pkg::DSRWD_ST_RUN; // [RL2]
                end else begin
                    rst_cnt_nxt = rst_cnt_r + 27'h1;
                end
            end
            dsrwd_pkg::DSRWD_ST_RUN: begin
                if (undervolt) begin
                    state_nxt = dsrwd_pkg::DSRWD_ST_UNDERVOLT; // [RL1]
                    rst_cnt_nxt = 27'h0;
                end
            end
            default: begin
                state_nxt = dsrwd_pkg::DSRWD_ST_UNDERVOLT;
                rst_cnt_nxt = 27'h0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_r <= dsrwd_pkg::DSRWD_ST_UNDERVOLT;
            rst_cnt_r <= 27'h0;
        end else begin
            state_r <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    // Reset depends only on supplies and the hold timer, never on the watchdog
    wire logic reset_active = (state_r != dsrwd_pkg::DSRWD_ST_RUN); // [RL9]

    // Watchdog counter; no enable exists, so an idle kick pin always expires
    logic [26:0] wd_cnt_r;
    logic [26:0] wd_cnt_nxt;
    logic wd_expired_r;
    logic wd_expired_nxt;

    wire logic wd_clear = reset_active | kick_edge; // [RL8]
    wire logic wd_overflow = (wd_cnt_r >= WD_TIMEOUT_CYC - 27'h1); // [RL5] [RL6]

    assign wd_cnt_nxt = wd_clear ? 27'h0 :
                        wd_overflow ? wd_cnt_r : wd_cnt_r + 27'h1; // [RL8] [RL12]
    // Only a kick transition releases a timeout
    assign wd_expired_nxt = kick_edge ? 1'b0 :
                            (!reset_active & wd_overflow) ? 1'b1 : wd_expired_r; // [RL6] [RL7]

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wd_cnt_r <= 27'h0;
            wd_expired_r <= 1'b0;
        end else begin
            wd_cnt_r <= wd_cnt_nxt;
            wd_expired_r <= wd_expired_nxt;
        end
    end

    // Output registers, active low
    logic rst_n_r;
    logic wdo_n_r;

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rst_n_r <= 1'b0;
            wdo_n_r <= 1'b0;
        end else begin
            rst_n_r <= ~(state_nxt != dsrwd_pkg::DSRWD_ST_RUN); // [RL13]
            // Undervolt drop releases at once, no hold period
            wdo_n_r <= ~(wd_expired_nxt |
                         (state_nxt == dsrwd_pkg::DSRWD_ST_UNDERVOLT)); // [RL10] [RL11] [RL13]
        end
    end

    // Open-drain builds drive low or release; push-pull always drives
    assign SUPERVISOR_RESET_N_OUT = RESET_OPEN_DRAIN ? 1'b0 : rst_n_r; // [RL14]
    assign SUPERVISOR_RESET_N_OE_N_OUT = RESET_OPEN_DRAIN ? rst_n_r : 1'b0; // [RL14]
    assign WATCHDOG_EXPIRED_N_OUT = WATCHDOG_OPEN_DRAIN ? 1'b0 : wdo_n_r; // [RL14]
    assign WATCHDOG_EXPIRED_N_OE_N_OUT = WATCHDOG_OPEN_DRAIN ? wdo_n_r : 1'b0; // [RL14]

endmodule
